// [rtl/uies_top.sv]
// uies_top: interrupt mask, source encoding and line status for one
// uart channel, reached over apb.
// assumes channel status inputs come from logic on SYS_CLK.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps

module uies_top
  import uies_pkg::*;
(
  // clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               RSTN,
  // apb slave
  input  wire logic               PSEL,
  input  wire logic               PENABLE,
  input  wire logic               PWRITE,
  input  wire logic [7:0]         PADDR,
  input  wire logic [31:0]        PWDATA,
  output logic      [31:0]        PRDATA,
  output logic                    PREADY,
  output logic                    PSLVERR,
  // channel status
  input  wire uies_pkg::uies_chan_s CHAN,
  input  wire logic               TX_WRITE,
  // outputs
  output logic                    IRQ_OUT,
  output logic                    SLEEP_EN
);
  import uies_pkg::*;

  uies_state_s st_ff;
  uies_state_s nxt_st;

  logic       fifo_mode;
  logic       rx_pend;
  logic       line_pend;
  logic       tx_pend;
  logic       modem_pend;
  logic [7:0] line_status;
  logic [7:0] src_code;
  logic       acc;
  logic       src_read;

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [7:0] ls,
                                         input logic [7:0] sc, input uies_state_s s,
                                         input logic [3:0] mc);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      OFS_INT_MASK:    r = {24'h00_0000, s.mask};
      OFS_LINE_STATUS: r = {24'h00_0000, ls};
      OFS_INT_SOURCE:  r = {24'h00_0000, sc};
      OFS_FIFO_CTRL:   r = {24'h00_0000, s.fifo_control_reg};
      OFS_ENH_FEAT:    r = {24'h00_0000, s.enhanced_feature_reg};
      OFS_MODEM_STAT:  r = {28'h000_0000, mc};
      OFS_RX_TRIG:     r = {24'h00_0000, s.trig};
      default:         r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a == OFS_INT_MASK) || (a == OFS_LINE_STATUS) || (a == OFS_INT_SOURCE) ||
           (a == OFS_FIFO_CTRL) || (a == OFS_ENH_FEAT) || (a == OFS_MODEM_STAT) ||
           (a == OFS_RX_TRIG);
  endfunction

  always_comb
  begin
    fifo_mode = st_ff.fifo_control_reg[FCR_FIFOEN];
    rx_pend = fifo_mode ? (CHAN.rx_count >= st_ff.trig) : (CHAN.rx_count != 8'h00);
    line_pend = |CHAN.rx_err;
    modem_pend = |CHAN.modem_chg;
    tx_pend = fifo_mode ? st_ff.tx_ev : CHAN.tx_empty;
    line_status = {CHAN.fifo_err, CHAN.tx_empty & CHAN.tsr_empty, CHAN.tx_empty,
                   CHAN.rx_err, CHAN.rx_count != 8'h00};
    // priority encoding, rx shown at trigger in fifo mode, at any held character otherwise
    if (st_ff.mask[MSK_LINE] && line_pend)
      src_code = SRC_LINE;
    else if (st_ff.mask[MSK_RX_READY_INDICATION] && rx_pend)
      src_code = SRC_RX;
    else if (st_ff.mask[MSK_TXE] && tx_pend)
      src_code = SRC_TX;
    else if (st_ff.mask[MSK_MODEM] && modem_pend)
      src_code = SRC_MODEM;
    else if (st_ff.mask[MSK_XOFF] && st_ff.xoff_ev)
      src_code = SRC_XOFF;
    else if ((st_ff.mask[MSK_CTS] && st_ff.cts_ev) || (st_ff.mask[MSK_RTS] && st_ff.rts_ev))
      src_code = SRC_FLOW;
    else
      src_code = SRC_NONE;
    acc = PSEL && PENABLE && st_ff.pready;
    src_read = acc && !PWRITE && (PADDR == OFS_INT_SOURCE);

    nxt_st = st_ff;
    nxt_st.pready = PSEL && !st_ff.pready;
    nxt_st.pslverr = PSEL && !st_ff.pready && !mapped(PADDR);
    if (PSEL && !st_ff.pready)
      nxt_st.prdata = rd_mux(PADDR, line_status, src_code, st_ff, CHAN.modem_chg);
    nxt_st.cts_d = CHAN.cts;
    nxt_st.rts_d = CHAN.rts;
    nxt_st.tx_e_d = CHAN.tx_empty;

    // event flags: clear on source read, set wins over clear
    // limitation: a flag set after the source word was latched is
    // cleared unseen by that same read
    if (src_read)
    begin
      nxt_st.cts_ev = 1'b0;
      nxt_st.rts_ev = 1'b0;
      nxt_st.xoff_ev = 1'b0;
      nxt_st.tx_ev = 1'b0;
    end
    if (TX_WRITE)
      nxt_st.tx_ev = 1'b0;
    if (CHAN.cts && !st_ff.cts_d)
      nxt_st.cts_ev = 1'b1;
    if (CHAN.rts && !st_ff.rts_d)
      nxt_st.rts_ev = 1'b1;
    if (CHAN.xoff_rx)
      nxt_st.xoff_ev = 1'b1;
    // fifo emptied by shifting
    // set wins over a same-cycle load, so an emptying edge is not lost to that load
    if (CHAN.tx_empty && !st_ff.tx_e_d)
      nxt_st.tx_ev = 1'b1;

    if (acc && PWRITE)
    begin
      unique case (PADDR)
        OFS_INT_MASK:
        begin
          nxt_st.mask[3:0] = PWDATA[3:0];
          if (st_ff.enhanced_feature_reg[EFR_ENH])
            nxt_st.mask[7:4] = PWDATA[7:4];
        end
        OFS_FIFO_CTRL: nxt_st.fifo_control_reg = PWDATA[7:0];
        OFS_ENH_FEAT:  nxt_st.enhanced_feature_reg = PWDATA[7:0];
        OFS_RX_TRIG:   nxt_st.trig = (PWDATA[7:0] == 8'h00) ? 8'h01 : PWDATA[7:0];
        default:       nxt_st.fifo_control_reg = st_ff.fifo_control_reg;
      endcase
    end
    nxt_st.sleep_en = st_ff.mask[MSK_SLEEP];
    nxt_st.irq = (src_code != SRC_NONE);
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      // idle transmitter reads empty: no false emptying edge after reset
      // mask cleared
      st_ff <= '{mask: RST_INT_MASK, fifo_control_reg: RST_FIFO_CTL, enhanced_feature_reg: RST_ENH_FEAT, trig: RST_RX_TRIG,
                 prdata: 32'h0000_0000, tx_e_d: RST_TX_IDLE, default: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign PRDATA   = st_ff.prdata;
  assign PREADY   = st_ff.pready;
  assign PSLVERR  = st_ff.pslverr;
  assign IRQ_OUT  = st_ff.irq;
  assign SLEEP_EN = st_ff.sleep_en;

  property p_cts;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (st_ff.mask[MSK_CTS] && CHAN.cts && !st_ff.cts_d) |-> ##2 IRQ_OUT;
  endproperty
  a_cts: assert property (p_cts) else $error("cts edge gave no irq");

  property p_rts;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (st_ff.mask[MSK_RTS] && CHAN.rts && !st_ff.rts_d) |-> ##2 IRQ_OUT;
  endproperty
  a_rts: assert property (p_rts) else $error("rts edge gave no irq");

  property p_xoff;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (st_ff.mask[MSK_XOFF] && CHAN.xoff_rx) |-> ##2 IRQ_OUT;
  endproperty
  a_xoff: assert property (p_xoff) else $error("xoff gave no irq");

  property p_sleep;
    @(posedge SYS_CLK) disable iff (!RSTN)
      ##1 (SLEEP_EN == $past(st_ff.mask[MSK_SLEEP]));
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep enable mismatch");

  property p_line;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (st_ff.mask[MSK_LINE] && |CHAN.rx_err) |=> IRQ_OUT;
  endproperty
  a_line: assert property (p_line) else $error("line error gave no irq");

  property p_rxlvl;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (st_ff.mask[MSK_RX_READY_INDICATION] && fifo_mode && CHAN.rx_count >= st_ff.trig && !line_pend)
        |-> src_code == SRC_RX;
  endproperty
  a_rxlvl: assert property (p_rxlvl) else $error("rx trigger not level 2");

  property p_poll;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (st_ff.mask == 8'h00) |=> !IRQ_OUT;
  endproperty
  a_poll: assert property (p_poll) else $error("irq in polled mode");

  property p_enh;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (acc && PWRITE && PADDR == OFS_INT_MASK && !st_ff.enhanced_feature_reg[EFR_ENH])
        |=> st_ff.mask[7:4] == $past(st_ff.mask[7:4]);
  endproperty
  a_enh: assert property (p_enh) else $error("upper mask written while locked");

  property p_tsr;
    @(posedge SYS_CLK) disable iff (!RSTN)
      line_status[6] |-> line_status[5];
  endproperty
  a_tsr: assert property (p_tsr) else $error("all-empty without fifo empty");

  property p_modem;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (st_ff.mask[MSK_MODEM] && modem_pend) |=> IRQ_OUT;
  endproperty
  a_modem: assert property (p_modem) else $error("modem change gave no irq");

  property p_txhold;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (st_ff.mask[MSK_TXE] && !fifo_mode && CHAN.tx_empty) |=> IRQ_OUT;
  endproperty
  a_txhold: assert property (p_txhold) else $error("empty holding gave no irq");

  property p_rxhold;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (st_ff.mask[MSK_RX_READY_INDICATION] && !fifo_mode && CHAN.rx_count != 8'h00) |=> IRQ_OUT;
  endproperty
  a_rxhold: assert property (p_rxhold) else $error("held character gave no irq");

  property p_rxsrc;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (fifo_mode && CHAN.rx_count < st_ff.trig) |-> (src_code != SRC_RX);
  endproperty
  a_rxsrc: assert property (p_rxsrc) else $error("rx shown below trigger");

  property p_lsr0;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (acc && !PWRITE && PADDR == OFS_LINE_STATUS)
        |-> PRDATA[0] == ($past(CHAN.rx_count) != 8'h00);
  endproperty
  a_lsr0: assert property (p_lsr0) else $error("data ready bit wrong");

  property p_lsr41;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (acc && !PWRITE && PADDR == OFS_LINE_STATUS)
        |-> PRDATA[4:1] == $past(CHAN.rx_err);
  endproperty
  a_lsr41: assert property (p_lsr41) else $error("receive error bits wrong");

  property p_lsr65;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (acc && !PWRITE && PADDR == OFS_LINE_STATUS)
        |-> PRDATA[6:5] == $past({CHAN.tx_empty & CHAN.tsr_empty, CHAN.tx_empty});
  endproperty
  a_lsr65: assert property (p_lsr65) else $error("transmit empty bits wrong");

  property p_lsr7;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (acc && !PWRITE && PADDR == OFS_LINE_STATUS)
        |-> PRDATA[7] == $past(CHAN.fifo_err);
  endproperty
  a_lsr7: assert property (p_lsr7) else $error("fifo error bit wrong");

  property p_fifo;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (acc && PWRITE && PADDR == OFS_FIFO_CTRL)
        |=> fifo_mode == $past(PWDATA[FCR_FIFOEN]);
  endproperty
  a_fifo: assert property (p_fifo) else $error("fifo mode not taken");

  property p_enhopen;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (acc && PWRITE && PADDR == OFS_INT_MASK && st_ff.enhanced_feature_reg[EFR_ENH])
        |=> st_ff.mask == $past(PWDATA[7:0]);
  endproperty
  a_enhopen: assert property (p_enhopen) else $error("open mask write lost");

  property p_lowmask;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (acc && PWRITE && PADDR == OFS_INT_MASK)
        |=> st_ff.mask[3:0] == $past(PWDATA[3:0]);
  endproperty
  a_lowmask: assert property (p_lowmask) else $error("lower mask write lost");

  property p_rst;
    @(posedge SYS_CLK)
      !RSTN |=> (st_ff.mask == RST_INT_MASK && !IRQ_OUT);
  endproperty
  a_rst: assert property (p_rst) else $error("mask not cleared by reset");

  property p_quiet;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (!(st_ff.mask[MSK_LINE] && line_pend) && !(st_ff.mask[MSK_RX_READY_INDICATION] && rx_pend) &&
       !(st_ff.mask[MSK_TXE] && tx_pend) && !(st_ff.mask[MSK_MODEM] && modem_pend) &&
       !(st_ff.mask[MSK_XOFF] && st_ff.xoff_ev) && !(st_ff.mask[MSK_CTS] && st_ff.cts_ev) &&
       !(st_ff.mask[MSK_RTS] && st_ff.rts_ev)) |=> !IRQ_OUT;
  endproperty
  a_quiet: assert property (p_quiet) else $error("irq without pending source");

  property p_prio;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (st_ff.mask[MSK_RX_READY_INDICATION] && rx_pend && st_ff.mask[MSK_TXE] && tx_pend &&
       !(st_ff.mask[MSK_LINE] && line_pend)) |-> (src_code == SRC_RX);
  endproperty
  a_prio: assert property (p_prio) else $error("tx reported over rx");

  property p_txev;
    @(posedge SYS_CLK) disable iff (!RSTN)
      (st_ff.mask[MSK_TXE] && fifo_mode && CHAN.tx_empty && !st_ff.tx_e_d)
        |-> ##2 IRQ_OUT;
  endproperty
  a_txev: assert property (p_txev) else $error("fifo emptying gave no irq");

  property p_txclr;
    @(posedge SYS_CLK) disable iff (!RSTN)
      ((src_read || TX_WRITE) && !(CHAN.tx_empty && !st_ff.tx_e_d)) |=> !st_ff.tx_ev;
  endproperty
  a_txclr: assert property (p_txclr) else $error("tx flag not cleared by host");

endmodule

// [rtl/uies_pkg.sv]
// uies_pkg: offsets, reset values, field positions and carriers for the
// uart channel interrupt mask / status block.
// assumes a 32-bit apb master; byte addresses are word aligned.
package uies_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_INT_MASK    = 8'h00;
  localparam logic [7:0] OFS_LINE_STATUS = 8'h04;
  localparam logic [7:0] OFS_INT_SOURCE  = 8'h08;
  localparam logic [7:0] OFS_FIFO_CTRL   = 8'h0C;
  localparam logic [7:0] OFS_ENH_FEAT    = 8'h10;
  localparam logic [7:0] OFS_MODEM_STAT  = 8'h14;
  localparam logic [7:0] OFS_RX_TRIG     = 8'h18;

  // reset values
  localparam logic [7:0] RST_INT_MASK = 8'h00;
  localparam logic [7:0] RST_FIFO_CTL = 8'h00;
  localparam logic [7:0] RST_ENH_FEAT = 8'h00;
  localparam logic [7:0] RST_RX_TRIG  = 8'h01;
  localparam logic       RST_TX_IDLE  = 1'b1;

  // field positions
  localparam int MSK_CTS    = 7;
  localparam int MSK_RTS    = 6;
  localparam int MSK_XOFF   = 5;
  localparam int MSK_SLEEP  = 4;
  localparam int MSK_MODEM  = 3;
  localparam int MSK_LINE   = 2;
  localparam int MSK_TXE    = 1;
  localparam int MSK_RX_READY_INDICATION  = 0;
  localparam int EFR_ENH    = 4;
  localparam int FCR_FIFOEN = 0;

  // interrupt source codes (priority level in bits 3:1 for line, rx, tx and modem)
  localparam logic [7:0] SRC_NONE  = 8'h01;
  localparam logic [7:0] SRC_LINE  = 8'h06;
  localparam logic [7:0] SRC_RX    = 8'h04;
  localparam logic [7:0] SRC_TX    = 8'h02;
  localparam logic [7:0] SRC_MODEM = 8'h00;
  localparam logic [7:0] SRC_XOFF  = 8'h10;
  localparam logic [7:0] SRC_FLOW  = 8'h20;

  // status coming from the rest of the channel (same clock)
  typedef struct packed {
    logic       cts;
    logic       rts;
    logic       xoff_rx;
    logic [3:0] modem_chg;
    logic [3:0] rx_err;
    logic       fifo_err;
    logic [7:0] rx_count;
    logic       tx_empty;
    logic       tsr_empty;
  } uies_chan_s;

  typedef struct packed {
    logic [7:0]  mask;
    logic [7:0]  fifo_control_reg;
    logic [7:0]  enhanced_feature_reg;
    logic [7:0]  trig;
    logic        cts_d;
    logic        rts_d;
    logic        cts_ev;
    logic        rts_ev;
    logic        xoff_ev;
    logic        tx_ev;
    logic        tx_e_d;
    logic        irq;
    logic        sleep_en;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } uies_state_s;

endpackage

// [verification/uies_host.sv]
// uies_host: apb master in the host processor's place.
// assumes each call starts just after a rising edge of clk.
`timescale 1ns/100ps
module uies_host (
  // clock
  input  wire logic        clk,
  // apb
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic err);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // no cycle count assumed: the bench watchdog ends a hang
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not look valid
    pwdata <= ~wd;
    @(posedge clk);
  endtask
endmodule

// [verification/uies_tb_top.sv]
// uies bench: random and corner stimulus on one channel's status.
// assumes the host model and the design share SYS_CLK.
`timescale 1ns/100ps
module uart_interrupt_enable_status_tb_top;
  import uies_pkg::*;
  logic        SYS_CLK;
  logic        RSTN;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        sleep;
  logic        tx_wr;
  uies_chan_s  chan;
  uies_chan_s  cv;
  logic [31:0] d;
  logic        e;
  logic [7:0]  src_tab [4];
  int          fail_count;
  int          total_checks;
  int          n;

  always #50 SYS_CLK = ~SYS_CLK;

  uies_top dut (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CHAN(chan), .TX_WRITE(tx_wr), .IRQ_OUT(irq), .SLEEP_EN(sleep));
  uies_host host (.clk(SYS_CLK), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic chk(input string nm, input logic [7:0] ex, input logic [31:0] got);
    total_checks++;
    if (got !== {24'h00_0000, ex})
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b0, a, 32'h0000_0000, d, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host.xfer(1'b1, a, {24'h00_0000, v}, d, e);
  endtask
  task automatic cirq(input logic ex);
    repeat (3) @(posedge SYS_CLK);
    chk("irq", {7'h00, ex}, {31'h0000_0000, irq});
  endtask
  function automatic logic [7:0] lsr_exp(input uies_chan_s c);
    return {c.fifo_err, c.tx_empty & c.tsr_empty, c.tx_empty, c.rx_err, |c.rx_count};
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    SYS_CLK = 1'b0;
    RSTN = 1'b0;
    chan = '0;
    tx_wr = 1'b0;
    fail_count = 0;
    total_checks = 0;
    src_tab = '{SRC_RX, SRC_TX, SRC_LINE, SRC_MODEM};
    void'($urandom(32'h0000_6ed7));
    repeat (4) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    @(posedge SYS_CLK);
    rd(OFS_INT_MASK);
    chk("mask_rst", RST_INT_MASK, d);
    rd(8'h1C);
    chk("unmapped_err", 8'h01, {31'h0000_0000, e});
    wr(OFS_INT_MASK, 8'hFF);
    rd(OFS_INT_MASK);
    chk("mask_locked", 8'h0F, d);
    wr(OFS_ENH_FEAT, 8'h10);
    wr(OFS_INT_MASK, 8'hFF);
    rd(OFS_INT_MASK);
    chk("mask_open", 8'hFF, d);
    chk("sleep", 8'h01, {31'h0000_0000, sleep});
    // reset again mid-run: everything back to defaults
    RSTN <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    RSTN <= 1'b1;
    @(posedge SYS_CLK);
    rd(OFS_INT_MASK);
    chk("mask_rerst", RST_INT_MASK, d);
    chk("sleep_rerst", 8'h00, {31'h0000_0000, sleep});
    wr(OFS_ENH_FEAT, 8'h10);
    $display("test registers done");
    wr(OFS_FIFO_CTRL, 8'h01);
    wr(OFS_INT_MASK, 8'h00);
    repeat (24)
    begin
      cv = uies_chan_s'(22'($urandom));
      cv.cts = 1'b0;
      cv.rts = 1'b0;
      cv.xoff_rx = 1'b0;
      chan <= cv;
      repeat (2) @(posedge SYS_CLK);
      rd(OFS_LINE_STATUS);
      chk("line_status", lsr_exp(cv), d);
      chk("irq_polled", 8'h00, {31'h0000_0000, irq});
    end
    $display("test polled done");
    wr(OFS_FIFO_CTRL, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      chan <= '0;
      wr(OFS_INT_MASK, 8'h01 << i);
      cv = '0;
      case (i)
        0: cv.rx_count = 8'h01;
        1: cv.tx_empty = 1'b1;
        2: cv.rx_err = 4'h8;
        default: cv.modem_chg = 4'h4;
      endcase
      chan <= cv;
      cirq(1'b1);
      rd(OFS_INT_SOURCE);
      chk("source", src_tab[i], d);
      chan <= '0;
      cirq(1'b0);
      chan <= cv;
      wr(OFS_INT_MASK, 8'h00);
      cirq(1'b0);
    end
    $display("test levels done");
    for (int i = 0; i < 6; i++)
    begin
      chan <= '0;
      wr(OFS_INT_MASK, (i < 3) ? (8'h80 >> i) : 8'h00);
      rd(OFS_INT_SOURCE);
      cv = '0;
      case (i % 3)
        0: cv.cts = 1'b1;
        1: cv.rts = 1'b1;
        default: cv.xoff_rx = 1'b1;
      endcase
      chan <= cv;
      @(posedge SYS_CLK);
      chan.xoff_rx <= 1'b0;
      cirq(i < 3);
      rd(OFS_INT_SOURCE);
      chk("evt_src", (i > 2) ? SRC_NONE : (i == 2) ? SRC_XOFF : SRC_FLOW, d);
      cirq(1'b0);
    end
    $display("test events done");
    wr(OFS_FIFO_CTRL, 8'h01);
    wr(OFS_RX_TRIG, 8'h04);
    wr(OFS_INT_MASK, 8'h01);
    for (int k = 0; k < 4; k++)
    begin
      n = (k == 3) ? 3 : k + 3;
      chan.rx_count <= 8'(n);
      cirq(n >= 4);
      rd(OFS_INT_SOURCE);
      chk("rx_src", (n >= 4) ? SRC_RX : SRC_NONE, d);
    end
    wr(OFS_INT_MASK, 8'h02);
    chan.tx_empty <= 1'b1;
    cirq(1'b1);
    tx_wr <= 1'b1;
    @(posedge SYS_CLK);
    tx_wr <= 1'b0;
    cirq(1'b0);
    chan.tx_empty <= 1'b0;
    @(posedge SYS_CLK);
    chan.tx_empty <= 1'b1;
    cirq(1'b1);
    rd(OFS_INT_SOURCE);
    chk("tx_src", SRC_TX, d);
    cirq(1'b0);
    // rx at trigger and tx emptied together: rx reported first
    wr(OFS_INT_MASK, 8'h03);
    chan.rx_count <= 8'h05;
    chan.tx_empty <= 1'b0;
    @(posedge SYS_CLK);
    chan.tx_empty <= 1'b1;
    cirq(1'b1);
    rd(OFS_INT_SOURCE);
    chk("prio_src", SRC_RX, d);
    $display("test fifo done");
    complete_run();
  end

  // the run needs well under 10k cycles
  initial
  begin
    #1_000_000;
    fail_count++;
    complete_run();
  end
endmodule
